// ==== bench/xbp_mem_model.sv ====
// Far side model: address latch, ROM (value is inverted address), RAM.
// Assumes the block owns the lines; reads answer after lat_wait cycles.
`timescale 1ns/1ps
module xbp_mem_model (
   input wire logic ref_clk,
   input wire logic program_store_strobe_n,
   input wire logic addr_latch_strobe,
   input wire logic [7:0] ad_out,
   input wire logic [7:0] ad_oe_n,
   input wire logic [3:0] lat_wait,
   output logic [7:0] ad_in
);
   logic [7:0] lat;
   logic [7:0] ram [256];
   logic [7:0] cnt = 8'h00;
   // Latch closes with the strobe; taken at the clock edge so that
   // strobe and lines changing in one step cannot race
   always @(posedge ref_clk)
      if (addr_latch_strobe)
         lat <= ad_out;
   // Data phase age; a driven data phase is a write
   always @(posedge ref_clk) begin
      cnt <= addr_latch_strobe ? 8'h00 : cnt + 8'h01;
      if (!addr_latch_strobe && ad_oe_n == 8'h00)
         ram[lat] <= ad_out;
   end
   // Address phase, driven or slow: a pattern that moves every cycle, never stale
   always_comb
      if (addr_latch_strobe || ad_oe_n != 8'hFF || cnt < lat_wait)
         ad_in = lat ^ 8'hA5 ^ cnt;
      else
         ad_in = program_store_strobe_n ? ram[lat] : ~lat;
endmodule // xbp_mem_model

// ==== bench/xbp_pins_properties.sv ====
// Checker of the bus and port 1 pin block.
// Sees only the top ports; bound to every xbp_pins instance.
`timescale 1ns/1ps
module xbp_pins_chk #(
   parameter int PORT_W = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire xbp_pkg::xbp_bus_req_s bus_req,
   input wire logic bus_busy,
   input wire logic program_store_strobe_n,
   input wire logic addr_latch_strobe,
   input wire logic [7:0] mux_addr_data_lines_out,
   input wire logic [7:0] mux_addr_data_lines_oe_n,
   input wire logic [PORT_W-1:0] port_wr_stb,
   input wire logic [PORT_W-1:0] port_wr_val,
   input wire logic [PORT_W-1:0] port_latch,
   input wire logic [PORT_W-1:0] gp_port_bits_in,
   input wire xbp_pkg::xbp_port_drv_s gp_port_drv,
   input wire xbp_pkg::xbp_alt_s alt_in,
   input wire logic [3:0] ext_irq_pulse,
   input wire logic timer2_out,
   input wire logic timer2_out_en
);
   // ********
   // Properties
   // ********
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Taken request; bit 0 is left out of the pull-down check
   // because timer 2 may also drive it
   wire take = bus_req.start && !bus_busy;
   wire code = bus_req.kind == xbp_pkg::XBP_CYC_CODE;
   wire [7:0] wr0 = port_wr_stb[7:0] & ~port_wr_val[7:0] & 8'hFE;

   chk_rst_strobe: assert property (disable iff (1'b0)
      reset |=> program_store_strobe_n) else $error("strobe low in reset");
   chk_rst_ale: assert property (disable iff (1'b0)
      reset |=> addr_latch_strobe) else $error("ale low in reset");
   chk_addr_phase: assert property (take |=> addr_latch_strobe &&
      mux_addr_data_lines_out == $past(bus_req.addr_lo) &&
      mux_addr_data_lines_oe_n == 8'h00) else $error("no address phase");
   chk_ale_pulse: assert property (addr_latch_strobe && bus_busy
      |=> !addr_latch_strobe && bus_busy) else $error("ale too long");
   chk_fetch_strobe: assert property (take && code
      |=> program_store_strobe_n ##1 !program_store_strobe_n)
      else $error("fetch strobe wrong");
   chk_bus_turn: assert property (take |=> ##1
      mux_addr_data_lines_oe_n == (($past(bus_req.kind, 2) ==
      xbp_pkg::XBP_CYC_DWR) ? 8'h00 : 8'hFF)) else $error("bus turn");
   chk_pull_down: assert property (|wr0 |=> ##1
      (gp_port_drv.pull_down[7:0] & $past(wr0, 2)) == $past(wr0, 2) &&
      (gp_port_drv.weak_up[7:0] & $past(wr0, 2)) == 8'h00)
      else $error("no pull-down");
   chk_boost_once: assert property (port_wr_stb[2] &&
      port_wr_val[2] && !port_latch[2] |=> ##1 gp_port_drv.strong_up[2]
      ##1 !gp_port_drv.strong_up[2] && gp_port_drv.weak_up[2])
      else $error("boost pulse wrong");
   chk_irq_rise: assert property ($rose(gp_port_bits_in[4])
      |-> ##2 ext_irq_pulse[0]) else $error("rising irq missed");
   chk_timer_alt: assert property (1'b1 |=>
      alt_in.timer2_ext_io == $past(gp_port_bits_in[0]) &&
      alt_in.timer2_capture_reload_trigger == $past(gp_port_bits_in[1]))
      else $error("timer 2 inputs wrong");
   chk_t2_low: assert property (timer2_out_en && !timer2_out
      |=> gp_port_drv.pull_down[0]) else $error("timer 2 low missing");
   chk_t2_high: assert property (timer2_out_en && timer2_out &&
      port_latch[0] |=> gp_port_drv.strong_up[0])
      else $error("timer 2 high missing");

   cover property (take && code);
   cover property (take && bus_req.kind == xbp_pkg::XBP_CYC_DWR);
   cover property (ext_irq_pulse[1]);
endmodule // xbp_pins_chk

bind xbp_pins xbp_pins_chk #(.PORT_W(PORT_W)) u_chk (.ref_clk, .reset,
   .bus_req, .bus_busy, .program_store_strobe_n, .addr_latch_strobe,
   .mux_addr_data_lines_out, .mux_addr_data_lines_oe_n, .port_wr_stb,
   .port_wr_val, .port_latch, .gp_port_bits_in, .gp_port_drv, .alt_in,
   .ext_irq_pulse, .timer2_out, .timer2_out_en);

// ==== bench/xbp_pins_tb.sv ====
// Self-checking testbench of the bus and port 1 pin block.
// Drives the core side; a model stands on the memory side.
`timescale 1ns/1ps
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin \
   bad_count++; $display("wrong value %0t %s", $time, m); end end
module xbp_pins_tb;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   xbp_pkg::xbp_bus_req_s rq = '0;
   logic busy, rvalid, psn, ale;
   logic [7:0] rdata, adi, ado, adoe, pin, sh [256];
   logic [7:0] stb = 8'h00, val = 8'h00, ext = 8'hFF;
   logic t2o = 1'b0, t2e = 1'b0;
   logic [3:0] wt = 4'h0, irq;
   xbp_pkg::xbp_port_drv_s drv;
   logic [7:0] rd_q [$];
   logic [3:0] irq_q [$];
   int bad_count = 0, samples_checked = 0, seed = 21275;

   xbp_pins dut (.ref_clk, .reset, .bus_req(rq), .bus_busy(busy),
      .bus_rdata(rdata), .bus_rvalid(rvalid),
      .program_store_strobe_n(psn), .addr_latch_strobe(ale),
      .mux_addr_data_lines_in(adi), .mux_addr_data_lines_out(ado),
      .mux_addr_data_lines_oe_n(adoe), .port_wr_stb(stb),
      .port_wr_val(val), .port_latch(), .gp_port_bits_in(pin),
      .gp_port_drv(drv), .timer2_out(t2o), .timer2_out_en(t2e),
      .alt_in(), .ext_irq_pulse(irq));
   xbp_mem_model mem (.ref_clk, .program_store_strobe_n(psn),
      .addr_latch_strobe(ale), .ad_out(ado), .ad_oe_n(adoe),
      .lat_wait(wt), .ad_in(adi));

   always #25 ref_clk = ~ref_clk;
   // Pin level: strong pull-down wins, else the outside driver decides
   always_comb
      for (int i = 0; i < 8; i++)
         pin[i] = (drv.pull_down[i] === 1'b1) ? 1'b0 : ext[i];

   // Each result takes the oldest note off its queue
   always @(posedge ref_clk) begin
      if (rvalid === 1'b1 && rd_q.size() == 0)
         `CHK(1'b1, 1'b0, "extra read")
      else if (rvalid === 1'b1)
         `CHK(rdata, rd_q.pop_front(), "read data")
      if (!reset && irq !== 4'h0 && irq_q.size() == 0)
         `CHK(irq, 4'h0, "extra irq")
      else if (!reset && irq !== 4'h0)
         `CHK(irq, irq_q.pop_front(), "irq pulse")
   end

   task automatic print_verdict;
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One bus cycle; dbl keeps start up while busy, which must be ignored
   task automatic bus(input xbp_pkg::xbp_kind_e k, input logic [7:0] a,
         input logic [7:0] d, input logic [3:0] w, input bit dbl);
      int n;
      n = 0;
      wt <= w;
      rq <= '{1'b1, k, a, d, 1'b0};
      if (k == xbp_pkg::XBP_CYC_CODE)
         rd_q.push_back(~a);
      else if (k == xbp_pkg::XBP_CYC_DRD)
         rd_q.push_back(sh[a]);
      else
         sh[a] = d;
      @(posedge ref_clk);
      if (dbl)
         @(posedge ref_clk);
      rq.start <= 1'b0;
      repeat (w + (dbl ? 1 : 2)) @(posedge ref_clk);
      rq.data_end <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (busy !== 1'b0 && n < 20);
      rq.data_end <= 1'b0;
      if (n >= 20) begin
         bad_count++;
         print_verdict();
      end
   endtask

   // Port write, then drive checked two cycles on
   task automatic pw(input int i, input logic v);
      stb[i] <= 1'b1;
      val[i] <= v;
      // Letting a pin go is an edge on bits 4 and 6, pulling it low on bits 5 and 7
      if (i > 3 && i[0] != v)
         irq_q.push_back(4'h1 << (i - 4));
      @(posedge ref_clk);
      stb[i] <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK({drv.pull_down[i], drv.strong_up[i], drv.weak_up[i]},
         v ? 3'b011 : 3'b100, "drive")
      repeat (xbp_pkg::XBP_BOOST_CYC) @(negedge ref_clk);
      `CHK(drv.strong_up[i], 1'b0, "boost end")
      @(posedge ref_clk);
   endtask

   // Reset held over three edges, levels checked while it stands
   task automatic rst_run;
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK({psn, ale, ado, adoe}, {2'b11, 8'hFF, 8'h00}, "reset bus")
      `CHK(drv, {8'h00, 8'h00, 8'hFF}, "reset port")
      @(posedge ref_clk);
      reset <= 1'b0;
   endtask

   initial begin
      rst_run();
      $display("test reset done");
      for (int i = 0; i < 9; i++) begin
         logic [7:0] a, d;
         a = 8'($random(seed));
         d = 8'($random(seed));
         bus(xbp_pkg::XBP_CYC_DWR, a, d, i % 3, 0);
         bus(xbp_pkg::XBP_CYC_DRD, a, 8'h00, i % 3, i == 1);
         bus(xbp_pkg::XBP_CYC_CODE, a, 8'h00, i % 3, i == 2);
      end
      $display("test bus done");
      rst_run();
      $display("test mid reset done");
      for (int i = 0; i < 8; i++) begin
         pw(i, 1'b0);
         pw(i, 1'b1);
      end
      $display("test port done");
      for (int i = 4; i < 8; i++) begin
         ext[i] <= 1'b0;
         if (i % 2)
            irq_q.push_back(4'h1 << (i - 4));
         repeat (4) @(posedge ref_clk);
         ext[i] <= 1'b1;
         if (i % 2 == 0)
            irq_q.push_back(4'h1 << (i - 4));
         repeat (4) @(posedge ref_clk);
      end
      repeat (40) begin
         ext[3:0] <= 4'($random(seed));
         t2o <= 1'($random(seed));
         t2e <= 1'($random(seed));
         @(posedge ref_clk);
      end
      ext <= 8'hFF;
      repeat (4) @(posedge ref_clk);
      `CHK(irq_q.size() + rd_q.size(), 0, "results missing")
      $display("test irq done");
      print_verdict();
   end
endmodule // xbp_pins_tb

// ==== hw/xbp_edge_det.sv ====
// Edge detector for one external interrupt pin.
// Assumes the pin is already synchronous to ref_clk.
`timescale 1ns/1ps
module xbp_edge_det #(
   parameter bit RISING = 1'b1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pin,
   output logic edge_pulse
);

   typedef struct packed {
      logic prev;
      logic pulse;
   } xbp_edge_st_s;

   xbp_edge_st_s st_r;
   xbp_edge_st_s st_nxt;

   // Rising or falling compare against the last sample
   always_comb begin
      st_nxt.prev = pin;
      st_nxt.pulse = RISING ? (pin && !st_r.prev) : (!pin && st_r.prev);
   end

   // Previous sample resets high for both edge senses
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '{prev: 1'b1, pulse: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign edge_pulse = st_r.pulse;

endmodule // xbp_edge_det

// ==== hw/xbp_pins.sv ====
// Pin logic of the multiplexed external bus and general-purpose port 1.
// Assumes the core issues bus cycles as requests and writes port bits
// as one-cycle strobes, all synchronous to ref_clk (20 MHz).
//
// Overview of operation
// - Program strobe low enables external ROM fetches
// - Program strobe high on data access, reset
// - Address strobe marks low address byte capture
// - Address strobe forced high during reset
// - Low address driven while address strobe high
// - Lines become bidirectional data after strobe falls
// - Multiplexed lines unwritable by software, high at reset
// - Port bits reset high on weak pull-up
// - Written zero enables strong pull-down until one
// - Zero-to-one write gives brief strong high drive
// - Bits 0,1 give timer 2 io, trigger
// - Bits 2,3 are plain port pins only
// - Bits 4,6 interrupts on rising edge
// - Bits 5,7 interrupts on falling edge
//
// Bus cycle, clock by clock once a request is taken:
//   address phase: address strobe high, low address byte driven
//   data phase: strobe low, write data driven or lines released
//   data phase ends on the core's end flag; reads return then
// Only a code fetch lowers the program strobe, so a data cycle can
// never enable the program store by mistake.
// Port 1: a one rests on the weak pull-up only, so an outside driver
// can pull the pin low and the bit doubles as an input.
// Limitation: cycle length and strobe stretch are set by the core
// through the end flag; this block adds no wait states of its own.
`timescale 1ns/1ps
module xbp_pins #(
   parameter int PORT_W = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   // Bus request from the core
   input wire xbp_pkg::xbp_bus_req_s bus_req,
   output logic bus_busy,
   output logic [7:0] bus_rdata,
   output logic bus_rvalid,
   // External bus pins
   output logic program_store_strobe_n,
   output logic addr_latch_strobe,
   input wire logic [7:0] mux_addr_data_lines_in,
   output logic [7:0] mux_addr_data_lines_out,
   output logic [7:0] mux_addr_data_lines_oe_n,
   // Port 1 software writes
   input wire logic [PORT_W-1:0] port_wr_stb,
   input wire logic [PORT_W-1:0] port_wr_val,
   output logic [PORT_W-1:0] port_latch,
   // Port 1 pins, split into input and drive controls
   input wire logic [PORT_W-1:0] gp_port_bits_in,
   output xbp_pkg::xbp_port_drv_s gp_port_drv,
   // Alternate functions
   input wire logic timer2_out,
   input wire logic timer2_out_en,
   output xbp_pkg::xbp_alt_s alt_in,
   output logic [3:0] ext_irq_pulse
);

   // ********************************************************
   // State
   // ********************************************************
   typedef struct packed {
      xbp_pkg::xbp_phase_e phase;
      xbp_pkg::xbp_kind_e kind;
      logic pss_n;
      logic ale;
      logic [7:0] ad_out;
      logic [7:0] ad_oe_n;
      logic [7:0] rdata;
      logic rvalid;
      xbp_pkg::xbp_port_drv_s drv;
      xbp_pkg::xbp_alt_s alt;
      logic [3:0] irq;
      logic [PORT_W-1:0] latch;
      logic busy;
   } xbp_st_s;

   xbp_st_s st_r;
   xbp_st_s st_nxt;

   logic [PORT_W-1:0] bit_latch;
   logic [PORT_W-1:0] bit_pd;
   logic [PORT_W-1:0] bit_su;
   logic [PORT_W-1:0] bit_wu;
   logic [3:0] irq_edge;

   // Drive of a bit, or-ing the timer 2 output into bit 0
   function automatic logic [PORT_W-1:0] add_t2(
      input logic [PORT_W-1:0] v,
      input logic set);
      logic [PORT_W-1:0] r;
      r = v;
      r[xbp_pkg::XBP_BIT_T2] = v[xbp_pkg::XBP_BIT_T2] | set;
      return r;
   endfunction

   // True for a data write, the only cycle that drives data out
   function automatic logic is_write(input xbp_pkg::xbp_kind_e k);
      return k == xbp_pkg::XBP_CYC_DWR;
   endfunction

   // ********************************************************
   // Port 1 bits
   // ********************************************************
   // Alternate use of each bit, all sharing one pin driver:
   //   bit 0: timer 2 external input, or output when enabled
   //   bit 1: timer 2 capture or reload trigger input
   //   bits 2, 3: plain port pins
   //   bits 4, 6: interrupts on a rising edge
   //   bits 5, 7: interrupts on a falling edge
   // Inputs are read from the pin, not the latch, so a bit used as
   // an input must first be written with a one.
   genvar gi;
   generate
      for (gi = 0; gi < PORT_W; gi++) begin : g_bit
         // Bits 2 and 3 have nothing else attached
         xbp_port_bit u_bit (
            .ref_clk(ref_clk),
            .reset(reset),
            .wr_stb(port_wr_stb[gi]),
            .wr_val(port_wr_val[gi]),
            .latch_q(bit_latch[gi]),
            .pull_down(bit_pd[gi]),
            .strong_up(bit_su[gi]),
            .weak_up(bit_wu[gi])
         );
      end
   endgenerate

   // ********************************************************
   // External interrupt edge detectors
   // ********************************************************
   // A pulse lasts one cycle and trails the pin edge by two clocks:
   // one in the detector, one in the output register
   xbp_edge_det #(.RISING(1'b1)) u_irq_b (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin(gp_port_bits_in[xbp_pkg::XBP_BIT_IRQ_B]),
      .edge_pulse(irq_edge[0])
   );
   xbp_edge_det #(.RISING(1'b0)) u_irq_c (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin(gp_port_bits_in[xbp_pkg::XBP_BIT_IRQ_C]),
      .edge_pulse(irq_edge[1])
   );
   xbp_edge_det #(.RISING(1'b1)) u_irq_d (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin(gp_port_bits_in[xbp_pkg::XBP_BIT_IRQ_D]),
      .edge_pulse(irq_edge[2])
   );
   xbp_edge_det #(.RISING(1'b0)) u_irq_e (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin(gp_port_bits_in[xbp_pkg::XBP_BIT_IRQ_E]),
      .edge_pulse(irq_edge[3])
   );

   // ********************************************************
   // Bus sequencer and pin mapping
   // ********************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      // Port drive is registered once more so outputs leave flops
      st_nxt.latch = bit_latch;
      st_nxt.drv.pull_down = bit_pd;
      // Timer 2 may drive bit 0 high when its latch holds a one
      st_nxt.drv.strong_up = add_t2(bit_su,
         timer2_out_en & timer2_out & bit_latch[xbp_pkg::XBP_BIT_T2]);
      st_nxt.drv.weak_up = bit_wu;
      if (timer2_out_en && !timer2_out) begin
         st_nxt.drv.pull_down[xbp_pkg::XBP_BIT_T2] = 1'b1;
      end
      // Alternate inputs are seen through the pins
      st_nxt.alt.timer2_ext_io =
         gp_port_bits_in[xbp_pkg::XBP_BIT_T2];
      st_nxt.alt.timer2_capture_reload_trigger =
         gp_port_bits_in[xbp_pkg::XBP_BIT_TIMER2_CAPTURE_RELOAD_TRIGGER];
      st_nxt.alt.ext_irq_b_rising =
         gp_port_bits_in[xbp_pkg::XBP_BIT_IRQ_B];
      st_nxt.alt.ext_irq_c_falling =
         gp_port_bits_in[xbp_pkg::XBP_BIT_IRQ_C];
      st_nxt.alt.ext_irq_d_rising =
         gp_port_bits_in[xbp_pkg::XBP_BIT_IRQ_D];
      st_nxt.alt.ext_irq_e_falling =
         gp_port_bits_in[xbp_pkg::XBP_BIT_IRQ_E];
      st_nxt.irq = irq_edge;

      case (st_r.phase)
         xbp_pkg::XBP_PH_IDLE: begin
            // Idle bus: strobe off, lines float high on outside pull-ups
            st_nxt.pss_n = 1'b1;
            st_nxt.ale = 1'b0;
            st_nxt.ad_oe_n = 8'hFF;
            if (bus_req.start) begin
               st_nxt.phase = xbp_pkg::XBP_PH_ADDR;
               st_nxt.kind = bus_req.kind;
               st_nxt.ale = 1'b1;
               st_nxt.ad_out = bus_req.addr_lo;
               st_nxt.ad_oe_n = 8'h00;
               st_nxt.pss_n = 1'b1;
            end
         end
         xbp_pkg::XBP_PH_ADDR: begin
            // Strobe falls and the address leaves the lines at the same edge
            st_nxt.phase = xbp_pkg::XBP_PH_DATA;
            st_nxt.ale = 1'b0;
            if (is_write(st_r.kind)) begin
               st_nxt.ad_out = bus_req.wdata;
               st_nxt.ad_oe_n = 8'h00;
            end else begin
               st_nxt.ad_oe_n = 8'hFF;
            end
            // Only a code fetch enables the program store
            st_nxt.pss_n =
               (st_r.kind != xbp_pkg::XBP_CYC_CODE);
         end
         xbp_pkg::XBP_PH_DATA: begin
            if (bus_req.data_end) begin
               st_nxt.phase = xbp_pkg::XBP_PH_IDLE;
               st_nxt.pss_n = 1'b1;
               st_nxt.ad_oe_n = 8'hFF;
               if (!is_write(st_r.kind)) begin
                  st_nxt.rdata = mux_addr_data_lines_in;
                  st_nxt.rvalid = 1'b1;
               end
            end
         end
         default: begin
            st_nxt.phase = xbp_pkg::XBP_PH_IDLE;
         end
      endcase
      // Busy kept as a flop so the output has no decode behind it
      st_nxt.busy = (st_nxt.phase != xbp_pkg::XBP_PH_IDLE);
   end

   // Reset forces both strobes high and the lines to their high level
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
         st_r.phase <= xbp_pkg::XBP_PH_IDLE;
         st_r.kind <= xbp_pkg::XBP_CYC_CODE;
         st_r.pss_n <= 1'b1;
         st_r.ale <= 1'b1;
         st_r.ad_out <= xbp_pkg::XBP_AD_RST;
         st_r.ad_oe_n <= 8'h00;
         st_r.drv.weak_up <= xbp_pkg::XBP_PORT_RST;
         st_r.latch <= xbp_pkg::XBP_PORT_RST;
         st_r.alt <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ********************************************************
   // Outputs, all straight from the state register
   // ********************************************************
   // No software path reaches the multiplexed lines at all
   assign mux_addr_data_lines_out = st_r.ad_out;
   assign mux_addr_data_lines_oe_n = st_r.ad_oe_n;
   assign program_store_strobe_n = st_r.pss_n;
   assign addr_latch_strobe = st_r.ale;

   // Core side of the bus
   assign bus_busy = st_r.busy;
   assign bus_rdata = st_r.rdata;
   assign bus_rvalid = st_r.rvalid;

   // Port 1 drive, latch copy and alternate inputs
   assign gp_port_drv = st_r.drv;
   assign port_latch = st_r.latch;
   assign alt_in = st_r.alt;
   assign ext_irq_pulse = st_r.irq;

endmodule // xbp_pins

// ==== hw/xbp_pkg.sv ====
// Package of the external bus and port 1 pin block.
// Assumes one core clock at 20 MHz and a synchronous active-high reset.
package xbp_pkg;

   // ********************************************************
   // Widths and reset levels
   // ********************************************************
   localparam int XBP_PORT_W = 8;
   localparam logic [7:0] XBP_PORT_RST = 8'hFF;
   localparam logic [7:0] XBP_AD_RST = 8'hFF;

   // ********************************************************
   // Port 1 bit positions of alternate functions
   // ********************************************************
   localparam int XBP_BIT_T2 = 0;
   localparam int XBP_BIT_TIMER2_CAPTURE_RELOAD_TRIGGER = 1;
   localparam int XBP_BIT_IRQ_B = 4;
   localparam int XBP_BIT_IRQ_C = 5;
   localparam int XBP_BIT_IRQ_D = 6;
   localparam int XBP_BIT_IRQ_E = 7;

   // ********************************************************
   // Timing: strong high pulse after a zero-to-one write
   // ********************************************************
   localparam int XBP_CLK_HZ = 20000000;
   localparam int XBP_BOOST_NS = 50;
   localparam int XBP_BOOST_CYC_RAW =
      (XBP_BOOST_NS * (XBP_CLK_HZ / 1000000) + 999) / 1000;
   localparam int XBP_BOOST_CYC =
      (XBP_BOOST_CYC_RAW < 1) ? 1 : XBP_BOOST_CYC_RAW;

   // ********************************************************
   // Bus cycle kinds and phases
   // ********************************************************
   typedef enum logic [1:0] {
      XBP_CYC_CODE,
      XBP_CYC_DRD,
      XBP_CYC_DWR
   } xbp_kind_e;

   typedef enum logic [1:0] {
      XBP_PH_IDLE,
      XBP_PH_ADDR,
      XBP_PH_DATA
   } xbp_phase_e;

   // Bus request from the core
   typedef struct packed {
      logic start;
      xbp_kind_e kind;
      logic [7:0] addr_lo;
      logic [7:0] wdata;
      logic data_end;
   } xbp_bus_req_s;

   // Pin drive of one port 1 bit group
   typedef struct packed {
      logic [7:0] pull_down;
      logic [7:0] strong_up;
      logic [7:0] weak_up;
   } xbp_port_drv_s;

   // Decoded alternate inputs of port 1
   typedef struct packed {
      logic timer2_ext_io;
      logic timer2_capture_reload_trigger;
      logic ext_irq_b_rising;
      logic ext_irq_c_falling;
      logic ext_irq_d_rising;
      logic ext_irq_e_falling;
   } xbp_alt_s;

endpackage

// ==== hw/xbp_port_bit.sv ====
// One quasi-bidirectional port 1 bit: latch, pull-down, boost pulse.
// Assumes writes are one-cycle strobes synchronous to ref_clk.
`timescale 1ns/1ps
module xbp_port_bit (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wr_stb,
   input wire logic wr_val,
   output logic latch_q,
   output logic pull_down,
   output logic strong_up,
   output logic weak_up
);

   typedef struct packed {
      logic latch;
      logic [7:0] boost;
   } xbp_bit_st_s;

   xbp_bit_st_s st_r;
   xbp_bit_st_s st_nxt;

   // ********************************************************
   // Latch and boost counter
   // ********************************************************
   always_comb begin
      st_nxt = st_r;
      if (st_r.boost != 8'h00) begin
         st_nxt.boost = st_r.boost - 8'h01;
      end
      if (wr_stb) begin
         st_nxt.latch = wr_val;
         if (wr_val && !st_r.latch) begin
            st_nxt.boost = 8'(xbp_pkg::XBP_BOOST_CYC);
         end
         if (!wr_val) begin
            st_nxt.boost = 8'h00;
         end
      end
   end

   // Reset leaves the bit high on its weak pull-up only
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '{latch: 1'b1, boost: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign latch_q = st_r.latch;
   assign pull_down = !st_r.latch;
   assign strong_up = st_r.latch && (st_r.boost != 8'h00);
   assign weak_up = st_r.latch;

endmodule // xbp_port_bit
